// *** design/spsc_pkg.sv ***
package spsc_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADR_POWER_CONTROL = 8'h00;
  localparam logic [7:0] ADR_OUTPUT_CONTROL = 8'h11;
  localparam logic [7:0] ADR_CORE_RESET = 8'h14;
  localparam logic [7:0] ADR_HCLK_MODE = 8'h24;
  localparam logic [7:0] ADR_STANDBY_LOW_POL = 8'h25;
  localparam logic [7:0] ADR_STANDBY_DEEP_POL = 8'h26;
  localparam logic [7:0] ADR_GPO_STANDBY_POL = 8'h27;
  localparam logic [7:0] ADR_GPO_ENABLE_LEVEL = 8'h7a;

  // ***************************************************************
  // Field layout
  // ***************************************************************
  localparam int STBY_LSB = 0;
  localparam int STBY_W = 2;
  localparam int STAT_SETTLED_BIT = 8;
  localparam int STAT_VDR_BIT = 9;
  localparam int VPOL_W = 25;
  localparam int XV_W = 24;
  localparam int SUBSTRATE_PULSE_BIT = 24;
  localparam int GPO_W = 8;
  localparam int GPO_LEVEL_LSB = 0;
  localparam int GPO_DEEP_LSB = 8;
  localparam int GPO_EN_LSB = 16;
  localparam int GPOREG_W = 24;
  localparam int HCLK_W = 8;
  localparam int DATA_OUT_W = 12;

  // ***************************************************************
  // Reset values and encodings
  // ***************************************************************
  typedef enum logic [1:0]
  {
    SPSC_FULL_POWER = 2'b00,
    SPSC_STANDBY_ONE = 2'b01,
    SPSC_STANDBY_TWO = 2'b10,
    SPSC_STANDBY_DEEP = 2'b11
  } spsc_level_t;
  localparam logic [1:0] STBY_RESET = 2'h3;
  localparam logic [7:0] HCLK_THREE_PHASE = 8'h10;
  localparam logic [7:0] HCLK_TWO_PHASE_IDLE = 8'haa;
  localparam logic [7:0] HCLK_ALL_LOW = 8'h00;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_FREQ_MHZ = 20;
  localparam int OSC_SETTLE_US = 500;
  localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_US * CLK_FREQ_MHZ;
  localparam int TOGGLE_INHIBIT_PIXELS = 36;
  localparam int SLAVE_RESET_DELAY = 3;

endpackage

// *** design/spsc_serial_port.sv ***
`timescale 1ns/100ps
module spsc_serial_port
  import spsc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 28
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic serialLoad_b,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic wrStrobe,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] wrData,
  input wire logic [DATA_W-1:0] rdData
);

  localparam int FRAME = 1 + ADDR_W + DATA_W;
  localparam int CNT_W = $clog2(FRAME + 1);

  if (ADDR_W < 7 || DATA_W < VPOL_W)
  begin : g_bad_width
    $error("spsc_serial_port: address or data too narrow");
  end

  typedef struct packed {
    logic [2:0] sck;
    logic [1:0] load;
    logic [1:0] din;
    logic [CNT_W-1:0] bitCnt;
    logic isRead;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] shift;
    logic sdo;
    logic sdoEn;
    logic strobe;
  } spsc_serial_t;

  spsc_serial_t st;
  spsc_serial_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.sck = {st.sck[1:0], serialClock};
    next_st.load = {st.load[0], serialLoad_b};
    next_st.din = {st.din[0], serialDataIn};
    next_st.strobe = 1'b0;
    if (st.load[1])
    begin
      // Commit only a complete write frame; short frames are dropped
      if (st.bitCnt == CNT_W'(FRAME) && !st.isRead)
      begin
        next_st.strobe = 1'b1;
      end
      next_st.bitCnt = '0;
      next_st.sdoEn = 1'b0;
    end
    else if (st.sck[1] && !st.sck[2] && st.bitCnt != CNT_W'(FRAME))
    begin
      next_st.bitCnt = st.bitCnt + 1'b1;
      if (st.bitCnt == '0)
      begin
        next_st.isRead = st.din[1];
      end
      else if (st.bitCnt <= CNT_W'(ADDR_W))
      begin
        next_st.addr = {st.din[1], st.addr[ADDR_W-1:1]};
        next_st.shift = {st.din[1], st.shift[DATA_W-1:1]};
      end
      else
      begin
        next_st.shift = {st.din[1], st.shift[DATA_W-1:1]};
      end
      if (st.isRead && st.bitCnt == CNT_W'(ADDR_W))
      begin
        // Address is complete this edge; readback leaves LSB first
        next_st.sdoEn = 1'b1;
        next_st.shift = rdData;
        next_st.sdo = rdData[0];
      end
      else if (st.sdoEn)
      begin
        next_st.sdo = st.shift[1];
        next_st.shift = {1'b0, st.shift[DATA_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '{sck: 3'h0, load: 2'h3, din: 2'h0, default: '0};
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign serialDataOut = st.sdo;
  assign serialDataOe = st.sdoEn;
  assign wrStrobe = st.strobe;
  assign wrData = st.shift;
  assign regAddr = (st.isRead && !st.load[1] && st.bitCnt == CNT_W'(ADDR_W)) ?
                   {st.din[1], st.addr[ADDR_W-1:1]} : st.addr;

endmodule

// *** design/spsc_power_ctrl.sv ***
`timescale 1ns/100ps
module spsc_power_ctrl
  import spsc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 28,
  parameter int PIX_W = 14,
  parameter int SETTLE_CYCLES = OSC_SETTLE_CYCLES,
  parameter int SET_W = 16,
  parameter int VDR_GPO_IDX = 0
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic serialLoad_b,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic slaveMode,
  input wire logic syncIdlePolarity,
  input wire logic vdPinIn,
  input wire logic hdPinIn,
  input wire logic vdTiming,
  input wire logic hdTiming,
  input wire logic [XV_W-1:0] xvTiming,
  input wire logic subckTiming,
  input wire logic [HCLK_W-1:0] hclkTiming,
  input wire logic hlTiming,
  input wire logic rgTiming,
  input wire logic dclkTiming,
  input wire logic [DATA_OUT_W-1:0] dataTiming,
  output logic vdOut,
  output logic hdOut,
  output logic syncOe,
  output logic [XV_W-1:0] verticalOut,
  output logic substrateClockOut,
  output logic [HCLK_W-1:0] hclkOut,
  output logic [HCLK_W-1:0] hclkOe,
  output logic lastHclkOut,
  output logic resetGateOut,
  output logic hlRgOe,
  output logic hMinDrive,
  output logic dataClockOut,
  output logic [DATA_OUT_W-1:0] dataOut,
  output logic [GPO_W-1:0] generalOut,
  output logic [GPO_W-1:0] generalOe,
  output logic verticalDriverEnable,
  output logic crystalDriveEn,
  output logic oscPowerOn,
  output logic afePowerOn,
  output logic refsPowerOn,
  output logic coreRunEn,
  output logic timingCoreRst_b,
  output logic oscSettled,
  output logic toggleInhibit,
  output logic counterReset
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************
  if (PIX_W < 7 || SETTLE_CYCLES < 1 || SETTLE_CYCLES >= 2 ** SET_W || VDR_GPO_IDX >= GPO_W)
  begin : g_bad_param
    $error("spsc_power_ctrl: parameter out of range");
  end

  localparam int DLY_W = $clog2(SLAVE_RESET_DELAY + 1);
  localparam logic [PIX_W-1:0] INHIBIT_LEN = PIX_W'(TOGGLE_INHIBIT_PIXELS);

  // ***************************************************************
  // Serial register port
  // ***************************************************************
  logic wrStrobe;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] rdData;

  spsc_serial_port #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_serial (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .serialLoad_b(serialLoad_b),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe),
    .wrStrobe(wrStrobe),
    .regAddr(regAddr),
    .wrData(wrData),
    .rdData(rdData)
  );

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [1:0] vdSync;
    logic [1:0] hdSync;
    logic vdPrev;
    logic hdPrev;
    spsc_level_t standby;
    logic coreRstBit;
    logic outCtlPend;
    logic outCtl;
    logic [HCLK_W-1:0] horizontal_clock_mode;
    logic [VPOL_W-1:0] polLow;
    logic [VPOL_W-1:0] polDeep;
    logic [GPOREG_W-1:0] gpoPol;
    logic [GPOREG_W-1:0] gpoPend;
    logic [GPOREG_W-1:0] gpoAct;
    logic dlyRun;
    logic [DLY_W-1:0] dlyCnt;
    logic [PIX_W-1:0] pixCnt;
    logic [PIX_W-1:0] lastLen;
    logic [SET_W-1:0] settleCnt;
    logic cntRst;
    logic vdO;
    logic hdO;
    logic [XV_W-1:0] xv;
    logic substrate_pulse;
    logic [HCLK_W-1:0] hclk;
    logic [HCLK_W-1:0] hOe;
    logic hl;
    logic rg;
    logic hlRgEn;
    logic data_clock_out;
    logic [DATA_OUT_W-1:0] data;
    logic [GPO_W-1:0] general_outputs;
  } spsc_state_t;

  spsc_state_t st;
  spsc_state_t next_st;

  logic deep;
  logic lowStby;
  logic disabled;
  logic vdEff;
  logic hdEff;
  logic vdFall;
  logic hdFall;
  logic inhibit;

  // ***************************************************************
  // Mode decode
  // ***************************************************************
  always_comb
  begin
    deep = (st.standby == SPSC_STANDBY_DEEP);
    lowStby = (st.standby == SPSC_STANDBY_ONE) || (st.standby == SPSC_STANDBY_TWO);
    disabled = !st.outCtl && !deep;
    // Slave syncs come from pins, so only the second stage is read
    vdEff = slaveMode ? st.vdSync[1] : vdTiming;
    hdEff = slaveMode ? st.hdSync[1] : hdTiming;
    vdFall = st.vdPrev && !vdEff;
    hdFall = st.hdPrev && !hdEff;
    inhibit = (st.lastLen > INHIBIT_LEN) && (st.pixCnt >= st.lastLen - INHIBIT_LEN);
  end

  // ***************************************************************
  // Register readback
  // ***************************************************************
  always_comb
  begin
    rdData = '0;
    unique case (regAddr)
      ADR_POWER_CONTROL:
      begin
        rdData[STBY_LSB +: STBY_W] = st.standby;
        rdData[STAT_SETTLED_BIT] = oscSettled;
        rdData[STAT_VDR_BIT] = verticalDriverEnable;
      end
      ADR_OUTPUT_CONTROL: rdData[0] = st.outCtlPend;
      ADR_CORE_RESET: rdData[0] = st.coreRstBit;
      ADR_HCLK_MODE: rdData[HCLK_W-1:0] = st.horizontal_clock_mode;
      ADR_STANDBY_LOW_POL: rdData[VPOL_W-1:0] = st.polLow;
      ADR_STANDBY_DEEP_POL: rdData[VPOL_W-1:0] = st.polDeep;
      ADR_GPO_STANDBY_POL: rdData[GPOREG_W-1:0] = st.gpoPol;
      ADR_GPO_ENABLE_LEVEL: rdData[GPOREG_W-1:0] = st.gpoPend;
      default: rdData = '0;
    endcase
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    next_st = st;
    next_st.vdSync = {st.vdSync[0], vdPinIn};
    next_st.hdSync = {st.hdSync[0], hdPinIn};
    next_st.vdPrev = vdEff;
    next_st.hdPrev = hdEff;
    next_st.cntRst = 1'b0;

    if (wrStrobe)
    begin
      unique case (regAddr)
        ADR_POWER_CONTROL: next_st.standby = spsc_level_t'(wrData[STBY_LSB +: STBY_W]);
        ADR_OUTPUT_CONTROL: next_st.outCtlPend = wrData[0];
        ADR_CORE_RESET: next_st.coreRstBit = wrData[0];
        ADR_HCLK_MODE: next_st.horizontal_clock_mode = wrData[HCLK_W-1:0];
        ADR_STANDBY_LOW_POL: next_st.polLow = wrData[VPOL_W-1:0];
        ADR_STANDBY_DEEP_POL: next_st.polDeep = wrData[VPOL_W-1:0];
        ADR_GPO_STANDBY_POL: next_st.gpoPol = wrData[GPOREG_W-1:0];
        ADR_GPO_ENABLE_LEVEL: next_st.gpoPend = wrData[GPOREG_W-1:0];
        default: next_st.standby = st.standby;
      endcase
    end

    if (vdFall)
    begin
      next_st.outCtl = st.outCtlPend;
      next_st.gpoAct = (wrStrobe && regAddr == ADR_GPO_ENABLE_LEVEL) ? wrData[GPOREG_W-1:0] : st.gpoPend;
    end

    // oscillator settle timer; deep standby restarts it
    if (deep)
    begin
      next_st.settleCnt = '0;
    end
    else if (st.settleCnt != SET_W'(SETTLE_CYCLES))
    begin
      next_st.settleCnt = st.settleCnt + 1'b1;
    end

    // counter reset on the horizontal fall, delayed in slave
    next_st.pixCnt = st.pixCnt + 1'b1;
    if (hdFall && slaveMode)
    begin
      next_st.dlyRun = 1'b1;
      next_st.dlyCnt = DLY_W'(SLAVE_RESET_DELAY);
    end
    else if (st.dlyRun)
    begin
      next_st.dlyCnt = st.dlyCnt - 1'b1;
      if (st.dlyCnt == DLY_W'(1))
      begin
        next_st.dlyRun = 1'b0;
      end
    end
    if ((hdFall && !slaveMode) || (st.dlyRun && st.dlyCnt == DLY_W'(1)))
    begin
      // Window length is learned from the previous line
      next_st.lastLen = st.pixCnt;
      next_st.pixCnt = '0;
      next_st.cntRst = 1'b1;
    end

    // ***************************************************************
    // Output patterns
    // ***************************************************************
    if (deep)
    begin
      next_st.xv = st.polDeep[XV_W-1:0];
      next_st.substrate_pulse = st.polDeep[SUBSTRATE_PULSE_BIT];
    end
    else if (disabled || lowStby)
    begin
      next_st.xv = st.polLow[XV_W-1:0];
      next_st.substrate_pulse = st.polLow[SUBSTRATE_PULSE_BIT];
    end
    else if (!inhibit)
    begin
      next_st.xv = xvTiming;
      next_st.substrate_pulse = subckTiming;
    end

    // deep: high-Z horizontal, everything else low
    if (deep)
    begin
      next_st.hOe = '0;
      next_st.hlRgEn = 1'b0;
      next_st.hclk = HCLK_ALL_LOW;
      next_st.hl = 1'b0;
      next_st.rg = 1'b0;
      next_st.vdO = 1'b0;
      next_st.hdO = 1'b0;
      next_st.data_clock_out = 1'b0;
      next_st.data = '0;
    end
    else if (disabled || lowStby)
    begin
      next_st.hOe = '1;
      next_st.hlRgEn = 1'b1;
      // idle horizontal pattern by clock mode
      next_st.hclk = (st.horizontal_clock_mode == HCLK_THREE_PHASE) ? HCLK_ALL_LOW : HCLK_TWO_PHASE_IDLE;
      next_st.hl = 1'b0;
      next_st.rg = 1'b0;
      next_st.data = '0;
      // standby one with outputs enabled keeps syncs and data clock running
      if (!disabled && st.standby == SPSC_STANDBY_ONE)
      begin
        next_st.vdO = vdTiming;
        next_st.hdO = hdTiming;
        next_st.data_clock_out = dclkTiming;
      end
      else
      begin
        next_st.vdO = syncIdlePolarity;
        next_st.hdO = syncIdlePolarity;
        next_st.data_clock_out = (!disabled && st.standby == SPSC_STANDBY_TWO) ? 1'b0 : dclkTiming;
      end
    end
    else
    begin
      next_st.hOe = '1;
      next_st.hlRgEn = 1'b1;
      next_st.hclk = hclkTiming;
      next_st.hl = hlTiming;
      next_st.rg = rgTiming;
      next_st.vdO = vdTiming;
      next_st.hdO = hdTiming;
      next_st.data_clock_out = dclkTiming;
      next_st.data = dataTiming;
    end

    if (deep)
    begin
      next_st.general_outputs = st.gpoPol[GPO_DEEP_LSB +: GPO_W];
    end
    else if (disabled || lowStby)
    begin
      next_st.general_outputs = st.gpoPol[GPO_LEVEL_LSB +: GPO_W];
    end
    else
    begin
      next_st.general_outputs = st.gpoAct[GPO_LEVEL_LSB +: GPO_W];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '{standby: SPSC_STANDBY_DEEP, default: '0};
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign vdOut = st.vdO;
  assign hdOut = st.hdO;
  // Sync pins turn around to inputs in slave mode
  assign syncOe = !slaveMode;
  assign verticalOut = st.xv;
  assign substrateClockOut = st.substrate_pulse;
  assign hclkOut = st.hclk;
  assign hclkOe = st.hOe;
  assign lastHclkOut = st.hl;
  assign resetGateOut = st.rg;
  assign hlRgOe = st.hlRgEn;
  assign hMinDrive = lowStby;
  assign dataClockOut = st.data_clock_out;
  assign dataOut = st.data;
  assign generalOut = st.general_outputs;
  assign generalOe = st.gpoAct[GPO_EN_LSB +: GPO_W];
  // driver enable follows the applied level bit outside deep standby
  assign verticalDriverEnable = st.gpoAct[GPO_LEVEL_LSB + VDR_GPO_IDX] && !deep;
  // oscillator and crystal drive off in standby two and deep standby
  assign oscPowerOn = !deep && (st.standby != SPSC_STANDBY_TWO);
  assign crystalDriveEn = oscPowerOn;
  assign afePowerOn = (st.standby == SPSC_FULL_POWER);
  assign refsPowerOn = (st.standby == SPSC_FULL_POWER) || (st.standby == SPSC_STANDBY_ONE);
  assign coreRunEn = refsPowerOn;
  // Core is held in reset while coreRunEn is low and until software writes one
  assign timingCoreRst_b = st.coreRstBit && coreRunEn;
  assign oscSettled = (st.settleCnt == SET_W'(SETTLE_CYCLES));
  assign toggleInhibit = inhibit;
  assign counterReset = st.cntRst;

endmodule

// *** testbench/spsc_host_model.sv ***
`timescale 1ns/100ps
// ***************************************************************
// Serial host: sends whole frames, clock still between frames
// ***************************************************************
module spsc_host_model
  import spsc_pkg::*;
(
  input wire logic clk,
  input wire logic serialDataOut,
  output logic serialLoad_b,
  output logic serialClock,
  output logic serialDataIn
);
  logic [36:0] frame;
  initial
  begin
    serialLoad_b = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [27:0] d, output logic [27:0] q);
    q = '0;
    frame = {d, a, rd};
    @(posedge clk);
    serialLoad_b <= 1'b0;
    for (int i = 0; i < 37; i++)
    begin
      serialDataIn <= frame[i];
      // Four clocks per phase beat the two-flop synchroniser
      wait_clk(4);
      if (i > 8)
        q[i-9] = serialDataOut;
      serialClock <= 1'b1;
      wait_clk(4);
      serialClock <= 1'b0;
    end
    wait_clk(4);
    serialLoad_b <= 1'b1;
    // Released line shows the inverse so stale data never looks valid
    serialDataIn <= ~frame[36];
    wait_clk(6);
  endtask
endmodule

// *** testbench/spsc_power_ctrl_checker.sv ***
`timescale 1ns/100ps
module spsc_power_ctrl_checker
  import spsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slaveMode,
  input wire logic vdTiming,
  input wire logic hdTiming,
  input wire logic [XV_W-1:0] verticalOut,
  input wire logic [HCLK_W-1:0] hclkOe,
  input wire logic hlRgOe,
  input wire logic hMinDrive,
  input wire logic [DATA_OUT_W-1:0] dataOut,
  input wire logic [GPO_W-1:0] generalOe,
  input wire logic verticalDriverEnable,
  input wire logic crystalDriveEn,
  input wire logic oscPowerOn,
  input wire logic afePowerOn,
  input wire logic refsPowerOn,
  input wire logic coreRunEn,
  input wire logic timingCoreRst_b,
  input wire logic toggleInhibit,
  input wire logic counterReset
);
  // ***************************************************************
  // Level three is the only state with oscillator off and full drive
  // ***************************************************************
  logic deep;
  assign deep = !oscPowerOn && !hMinDrive;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_osc_crystal_pair: assert property (oscPowerOn == crystalDriveEn)
    else $error("crystal drive and oscillator power differ");
  a_full_power_set: assert property (afePowerOn |-> oscPowerOn && refsPowerOn && coreRunEn)
    else $error("full power without core, oscillator or references");
  a_min_drive_lvl: assert property (hMinDrive |-> !afePowerOn && refsPowerOn == oscPowerOn)
    else $error("minimum drive in wrong power state");
  a_core_reset_gate: assert property (!coreRunEn |-> !timingCoreRst_b)
    else $error("core released while stopped");
  a_deep_driver_off: assert property (deep |-> !verticalDriverEnable)
    else $error("driver enable high in deep standby");
  a_deep_pins_off: assert property (deep && $past(deep) |-> hclkOe == '0 && !hlRgOe && dataOut == '0)
    else $error("deep standby output pattern wrong");
  a_vdr_frame_hold: assert property (!slaveMode && vdTiming && $past(vdTiming) && $past(vdTiming, 2)
    && !deep && !$past(deep) |-> $stable(verticalDriverEnable))
    else $error("driver enable moved away from frame sync");
  a_gpo_frame_hold: assert property (!slaveMode && vdTiming && $past(vdTiming) && $past(vdTiming, 2)
    |-> $stable(generalOe))
    else $error("general output enables moved away from frame sync");
  a_line_ctr_reset: assert property (!slaveMode && coreRunEn && timingCoreRst_b && $fell(hdTiming)
    |-> ##[1:4] counterReset)
    else $error("counter reset missing after line sync");
  a_inhibit_hold: assert property (toggleInhibit && $past(toggleInhibit) && afePowerOn && $past(afePowerOn)
    && vdTiming && $past(vdTiming) |-> $stable(verticalOut))
    else $error("vertical output toggled in inhibit region");
endmodule
bind spsc_power_ctrl spsc_power_ctrl_checker u_chk (.clk, .rst_b, .slaveMode, .vdTiming, .hdTiming, .verticalOut,
  .hclkOe, .hlRgOe, .hMinDrive, .dataOut, .generalOe, .verticalDriverEnable, .crystalDriveEn, .oscPowerOn,
  .afePowerOn, .refsPowerOn, .coreRunEn, .timingCoreRst_b, .toggleInhibit, .counterReset);

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import spsc_pkg::*;
;
  logic clk, rst_b, ce, slaveMode, syncIdlePolarity, vdPinIn, hdPinIn, vdTiming, hdTiming, subckTiming;
  logic hlTiming, rgTiming, dclkTiming, serialLoad_b, serialClock, serialDataIn;
  logic [XV_W-1:0] xvTiming;
  logic [HCLK_W-1:0] hclkTiming, prevHclk;
  logic [DATA_OUT_W-1:0] dataTiming;
  logic serialDataOut, serialDataOe, vdOut, hdOut, syncOe, substrateClockOut, lastHclkOut, resetGateOut, hlRgOe;
  logic hMinDrive, dataClockOut, verticalDriverEnable, crystalDriveEn, oscPowerOn, afePowerOn, refsPowerOn;
  logic coreRunEn, timingCoreRst_b, oscSettled, toggleInhibit, counterReset;
  logic [XV_W-1:0] verticalOut;
  logic [HCLK_W-1:0] hclkOut, hclkOe;
  logic [DATA_OUT_W-1:0] dataOut;
  logic [GPO_W-1:0] generalOut, generalOe, lv;
  logic [31:0] seed, r;
  logic [27:0] q, p25, p26, p27;
  logic [9:0] cyc;
  logic [27:0] expQ[$], obsQ[$];
  string nameQ[$];
  int n_mismatch, tests_run;
  spsc_power_ctrl #(.SETTLE_CYCLES(20)) DUT (.clk, .rst_b, .ce, .serialLoad_b, .serialClock, .serialDataIn,
    .serialDataOut, .serialDataOe, .slaveMode, .syncIdlePolarity, .vdPinIn, .hdPinIn, .vdTiming, .hdTiming,
    .xvTiming, .subckTiming, .hclkTiming, .hlTiming, .rgTiming, .dclkTiming, .dataTiming, .vdOut, .hdOut, .syncOe,
    .verticalOut, .substrateClockOut, .hclkOut, .hclkOe, .lastHclkOut, .resetGateOut, .hlRgOe, .hMinDrive,
    .dataClockOut, .dataOut, .generalOut, .generalOe, .verticalDriverEnable, .crystalDriveEn, .oscPowerOn,
    .afePowerOn, .refsPowerOn, .coreRunEn, .timingCoreRst_b, .oscSettled, .toggleInhibit, .counterReset);
  spsc_host_model host (.clk, .serialDataOut, .serialLoad_b, .serialClock, .serialDataIn);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [27:0] d);
    logic [27:0] x;
    host.xfer(1'b0, a, d, x);
    settle(2);
  endtask
  task automatic chk(input string nm, input logic [27:0] o, input logic [27:0] e);
    nameQ.push_back(nm);
    expQ.push_back(e);
    obsQ.push_back(o);
  endtask
  task automatic wait_vd();
    logic last;
    last = vdTiming;
    for (int n = 0; n < 2100; n++)
    begin
      settle(1);
      if (last === 1'b1 && vdTiming === 1'b0)
        break;
      last = vdTiming;
    end
    settle(4);
  endtask
  task automatic wrap_up();
    wait (obsQ.size() == 0);
    #1;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ***************************************************************
  // Timing core stand-in: random levels, lines of 128, frames of 1024
  // ***************************************************************
  always @(posedge clk)
  begin
    r = xs();
    cyc <= rst_b ? cyc + 10'h001 : 10'h000;
    {hclkTiming, xvTiming} <= r;
    {dclkTiming, rgTiming, hlTiming} <= r[27:25];
    // no substrate toggle at line start
    subckTiming <= (cyc[6:0] < 7'h04) ? 1'b0 : r[24];
    syncIdlePolarity <= r[28];
    // slave pins fall with the syncs
    hdPinIn <= cyc[6:0] > 7'h02;
    vdPinIn <= cyc[9:0] > 10'h003;
    dataTiming <= r[11:0];
    hdTiming <= cyc[6:0] > 7'h02;
    vdTiming <= cyc[9:0] > 10'h003;
    prevHclk <= hclkTiming;
  end
  always
  begin
    wait (obsQ.size() != 0);
    tests_run++;
    if (obsQ[0] !== expQ[0])
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nameQ[0], expQ[0], obsQ[0]);
    end
    void'(nameQ.pop_front());
    void'(expQ.pop_front());
    void'(obsQ.pop_front());
  end
  initial
  begin
    #(50 * 40000);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    {rst_b, slaveMode} = '0;
    ce = 1'b1;
    n_mismatch = 0;
    tests_run = 0;
    seed = 32'h0000_0021;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    settle(2);
    chk("hoe", 28'(hclkOe), '0);
    chk("osc", 28'(oscPowerOn), '0);
    chk("goe", 28'(generalOe), '0);
    host.xfer(1'b1, ADR_POWER_CONTROL, '0, q);
    chk("rd00", q, 28'h000_0003);
    chk("sdoe", 28'(serialDataOe), '0);
    $display("test reset done");
    p25 = 28'(xs() & 32'h01ff_ffff);
    p26 = 28'(xs() & 32'h01ff_ffff);
    p27 = 28'(xs() & 32'h0000_ffff);
    lv = 8'(xs()) | 8'h01;
    wr(ADR_STANDBY_LOW_POL, p25);
    wr(ADR_STANDBY_DEEP_POL, p26);
    wr(ADR_GPO_STANDBY_POL, p27);
    host.xfer(1'b1, ADR_STANDBY_LOW_POL, '0, q);
    chk("rd25", q, p25);
    host.xfer(1'b1, 8'h3f, '0, q);
    chk("rdnone", q, '0);
    wait_vd();
    wr(ADR_GPO_ENABLE_LEVEL, {12'h0ff, 8'h00, lv});
    chk("goe", 28'(generalOe), '0);
    wait_vd();
    chk("goe", 28'(generalOe), 28'h000_00ff);
    $display("test program done");
    for (int lvl = 0; lvl < 4; lvl++)
    begin
      wr(ADR_POWER_CONTROL, 28'(lvl));
      chk("osc", 28'(oscPowerOn), 28'(lvl < 2));
      chk("afe", 28'(afePowerOn), 28'(lvl == 0));
      chk("hmin", 28'(hMinDrive), 28'(lvl == 1 || lvl == 2));
      chk("vout", 28'({substrateClockOut, verticalOut}), lvl == 3 ? p26 : p25);
      chk("gpo", 28'(generalOut), lvl == 3 ? 28'(p27[15:8]) : 28'(p27[7:0]));
      chk("hoe", 28'(hclkOe), lvl == 3 ? '0 : 28'h000_00ff);
      chk("vdr", 28'(verticalDriverEnable), 28'(lvl != 3));
      chk("data", 28'(dataOut), '0);
      chk("hlrg", 28'({lastHclkOut, resetGateOut, hlRgOe}), 28'(lvl != 3));
      if (lvl == 3)
        chk("data_clock_out", 28'({dataClockOut, vdOut, hdOut}), '0);
      if (lvl < 3)
        chk("hclk", 28'(hclkOut), 28'(HCLK_TWO_PHASE_IDLE));
    end
    $display("test standby done");
    wr(ADR_POWER_CONTROL, '0);
    wait_vd();
    wr(ADR_GPO_ENABLE_LEVEL, {12'h0ff, 8'h00, lv & 8'hfe});
    chk("vdr", 28'(verticalDriverEnable), 28'h000_0001);
    wait_vd();
    chk("vdr", 28'(verticalDriverEnable), '0);
    wr(ADR_OUTPUT_CONTROL, 28'h000_0001);
    chk("hclk", 28'(hclkOut), 28'(HCLK_TWO_PHASE_IDLE));
    wait_vd();
    chk("hclk", 28'(hclkOut), 28'(prevHclk));
    chk("glv", 28'(generalOut), 28'(lv & 8'hfe));
    wr(ADR_POWER_CONTROL, 28'h000_0001);
    chk("vout", 28'({substrateClockOut, verticalOut}), p25);
    wr(ADR_HCLK_MODE, 28'(HCLK_THREE_PHASE));
    chk("hclk", 28'(hclkOut), '0);
    wr(ADR_POWER_CONTROL, 28'h000_0003);
    chk("hoe", 28'(hclkOe), '0);
    $display("test frame sync done");
    wr(ADR_POWER_CONTROL, '0);
    chk("settle", 28'(oscSettled), '0);
    settle(30);
    chk("settle", 28'(oscSettled), 28'h000_0001);
    chk("corerst", 28'(timingCoreRst_b), '0);
    wr(ADR_CORE_RESET, '0);
    wr(ADR_CORE_RESET, 28'h000_0001);
    chk("corerst", 28'(timingCoreRst_b), 28'h000_0001);
    wait_vd();
    @(posedge clk);
    slaveMode <= 1'b1;
    wait_vd();
    chk("cntrst", 28'(counterReset), '0);
    settle(SLAVE_RESET_DELAY - 1);
    chk("cntrst", 28'(counterReset), 28'h000_0001);
    chk("syncoe", 28'(syncOe), '0);
    settle(600);
    $display("test restart done");
    wrap_up();
  end
endmodule
